/* File: hdl/etc_pin_sync.sv */
// Purpose: synchroniser and edge detector for the external event pin
// Assumes: pin may be asynchronous
// Notes:   first flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module etc_pin_sync (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } etc_sync_state_t;

    etc_sync_state_t st_q;
    etc_sync_state_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.s2;
    assign rise  = st_q.s2 & ~st_q.s3; // R21
    assign fall  = ~st_q.s2 & st_q.s3; // R21

endmodule
`default_nettype wire

/* File: hdl/etc_pkg.sv */
// Purpose: shared constants and types for the 8-bit event timer counter
// Assumes: apb slave with 32-bit data, one word per register
// Notes:   offsets chosen for this block
package etc_pkg;

    localparam logic [11:0] ETC_OFF_COUNT   = 12'h000;
    localparam logic [11:0] ETC_OFF_CONTROL = 12'h004;

    localparam logic [7:0] ETC_COUNT_RST   = 8'h00;
    localparam logic [7:0] ETC_CONTROL_RST = 8'h08;
    localparam logic [7:0] ETC_COUNT_MAX   = 8'hff;

    localparam int ETC_MODE_HI  = 7;
    localparam int ETC_MODE_LO  = 6;
    localparam int ETC_SRC_BIT  = 5;
    localparam int ETC_EN_BIT   = 4;
    localparam int ETC_EDGE_BIT = 3;
    localparam int ETC_PSC_HI   = 2;

    localparam int ETC_PSC_STAGES = 8;

    typedef enum logic [1:0] {
        ETC_MODE_UNUSED = 2'b00,
        ETC_MODE_EVENT  = 2'b01,
        ETC_MODE_TIMER  = 2'b10,
        ETC_MODE_PULSE  = 2'b11
    } etc_mode_t;

    typedef struct packed {
        etc_mode_t  mode_select;
        logic       internal_source_select;
        logic       count_enable_bit;
        logic       active_edge_select;
        logic [2:0] prescale_select;
    } etc_control_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } etc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } etc_apb_rsp_t;

endpackage

/* File: hdl/etc_prescaler.sv */
// Purpose: power-of-two divider of the selected internal tick
// Assumes: src_tick is a one-cycle enable pulse
// Notes:   tick_out pulses once per 2**psc input ticks
`timescale 1ns/1ps
`default_nettype none
module etc_prescaler (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       clear,
    input  wire logic       src_tick,
    input  wire logic [2:0] psc,
    output logic            tick_out
);
    import etc_pkg::*;

    typedef struct packed {
        logic [ETC_PSC_STAGES-2:0] cnt;
    } etc_psc_state_t;

    etc_psc_state_t st_q;
    etc_psc_state_t st_d;
    logic [ETC_PSC_STAGES-1:0] stage_hit;

    // stage k fires when the low k count bits are all ones
    genvar k;
    generate
        for (k = 0; k < ETC_PSC_STAGES; k++) begin : g_stage
            if (k == 0) begin : g_zero
                assign stage_hit[k] = src_tick;
            end else begin : g_more
                assign stage_hit[k] = src_tick & (&st_q.cnt[k-1:0]);
            end
        end
    endgenerate

    always_comb begin
        st_d = st_q;
        if (clear) begin
            st_d.cnt = '0;
        end else if (src_tick) begin
            st_d.cnt = st_q.cnt + {{(ETC_PSC_STAGES-2){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick_out = stage_hit[psc]; // R18

endmodule
`default_nettype wire

/* File: hdl/etc_timer.sv */
// Purpose: 8-bit count-up timer / event counter with apb registers
// Assumes: sub_tick is a one-cycle pulse at the sub clock rate
// Notes:   overflow_pulse is the internal interrupt request
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1 - eight-bit up counter, software loadable
// R2 - timer and pulse modes use prescaled clock
// R3 - source bit picks system or sub clock
// R4 - event mode counts selected pin edges
// R5 - increment by one per count event
// R6 - past FFH raise overflow request
// R7 - overflow reloads preload and keeps counting
// R8 - count register read returns live count
// R9 - write while stopped loads counter too
// R10 - write while running only updates preload
// R11 - software clears preload for full range
// R12 - enable bit runs, clear holds value
// R13 - two-bit field selects operating mode
// R14 - source and prescale ignored in event mode
// R15 - edge bit sets pin polarity used
// R16 - software programs control before use
// R17 - 01 event, 10 timer, 11 pulse
// R18 - prescale divides by two to the field
// R19 - edge 0 rising or low pulse
// R20 - pulse mode gated, enable self clears
// R21 - pin synchronised and edge detected
module etc_timer (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire etc_pkg::etc_apb_req_t apb_req,
    output etc_pkg::etc_apb_rsp_t      apb_rsp,
    input  wire logic                  sub_tick,
    input  wire logic                  external_event_pin,
    output logic                       overflow_pulse,
    output logic [7:0]                 count_out
);
    import etc_pkg::*;

    typedef struct packed {
        logic [7:0]   count;
        logic [7:0]   preload;
        etc_control_t ctrl;
        logic         pulse_run;
        logic         ovf;
        logic [31:0]  rdata;
    } etc_state_t;

    etc_state_t st_q;
    etc_state_t st_d;

    logic pin_level;
    logic pin_rise;
    logic pin_fall;
    logic src_tick;
    logic psc_tick;
    logic psc_clear;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic act_edge;
    logic end_edge;
    logic cnt_evt;
    logic mode_timer;
    logic mode_event;
    logic mode_pulse;

    etc_pin_sync u_sync (
        .clk    (clk),
        .reset  (reset),
        .pin_in (external_event_pin),
        .level  (pin_level),
        .rise   (pin_rise),
        .fall   (pin_fall)
    );

    // system clock ticks every cycle; sub clock by its pulse
    assign src_tick = st_q.ctrl.internal_source_select ? sub_tick : 1'b1; // R3
    assign psc_clear = ~st_q.ctrl.count_enable_bit;

    etc_prescaler u_psc (
        .clk      (clk),
        .reset    (reset),
        .clear    (psc_clear),
        .src_tick (src_tick),
        .psc      (st_q.ctrl.prescale_select),
        .tick_out (psc_tick)
    );

    assign mode_event = st_q.ctrl.mode_select == ETC_MODE_EVENT; // R17
    assign mode_timer = st_q.ctrl.mode_select == ETC_MODE_TIMER; // R17
    assign mode_pulse = st_q.ctrl.mode_select == ETC_MODE_PULSE; // R17

    // edge polarity: 0 means rising active for events, falling for pulse
    always_comb begin
        act_edge = 1'b0;
        end_edge = 1'b0;
        if (mode_event) begin
            act_edge = st_q.ctrl.active_edge_select ? pin_fall : pin_rise; // R19
        end else begin
            act_edge = st_q.ctrl.active_edge_select ? pin_rise : pin_fall; // R15
            end_edge = st_q.ctrl.active_edge_select ? pin_fall : pin_rise; // R19
        end
    end

    // count event per mode
    always_comb begin
        cnt_evt = 1'b0;
        if (st_q.ctrl.count_enable_bit) begin // R12
            case (st_q.ctrl.mode_select)
                ETC_MODE_TIMER: cnt_evt = psc_tick; // R2
                ETC_MODE_EVENT: cnt_evt = act_edge; // R4 R14
                ETC_MODE_PULSE: cnt_evt = psc_tick & st_q.pulse_run; // R2
                default:        cnt_evt = 1'b0;
            endcase
        end
    end

    assign addr_ok = (apb_req.paddr == ETC_OFF_COUNT) ||
                     (apb_req.paddr == ETC_OFF_CONTROL);
    assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_en = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

    always_comb begin
        st_d     = st_q;
        st_d.ovf = 1'b0;
        // counting and overflow
        if (cnt_evt) begin
            if (st_q.count == ETC_COUNT_MAX) begin // R6
                st_d.ovf   = 1'b1; // R6
                st_d.count = st_q.preload; // R7
            end else begin
                st_d.count = st_q.count + 8'h01; // R5 R1
            end
        end
        // pulse gate start and stop
        if (mode_pulse && st_q.ctrl.count_enable_bit) begin
            if (!st_q.pulse_run && act_edge) begin
                st_d.pulse_run = 1'b1; // R20
            end else if (st_q.pulse_run && end_edge) begin
                st_d.pulse_run = 1'b0; // R20
                st_d.ctrl.count_enable_bit = 1'b0; // R20
            end
        end
        if (!st_q.ctrl.count_enable_bit || !mode_pulse) begin
            st_d.pulse_run = 1'b0;
        end
        // register writes
        if (wr_en) begin
            if (apb_req.paddr == ETC_OFF_COUNT) begin
                st_d.preload = apb_req.pwdata[7:0]; // R10
                if (!st_q.ctrl.count_enable_bit) begin
                    st_d.count = apb_req.pwdata[7:0]; // R9
                end
            end else if (apb_req.paddr == ETC_OFF_CONTROL) begin
                st_d.ctrl = etc_control_t'(apb_req.pwdata[7:0]); // R13
                st_d.pulse_run = 1'b0;
            end
        end
        // read data captured in setup cycle
        if (rd_en) begin
            if (apb_req.paddr == ETC_OFF_COUNT) begin
                st_d.rdata = {24'h00_0000, st_q.count}; // R8
            end else if (apb_req.paddr == ETC_OFF_CONTROL) begin
                st_d.rdata = {24'h00_0000, st_q.ctrl};
            end else begin
                st_d.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q.count     <= ETC_COUNT_RST;
            st_q.preload   <= ETC_COUNT_RST;
            st_q.ctrl      <= etc_control_t'(ETC_CONTROL_RST);
            st_q.pulse_run <= 1'b0;
            st_q.ovf       <= 1'b0;
            st_q.rdata     <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
        end
    end

    assign apb_rsp.prdata  = st_q.rdata;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~addr_ok;
    assign overflow_pulse  = st_q.ovf;
    assign count_out       = st_q.count;

    // assertions
    property p_overflow_reload;
        @(posedge clk) disable iff (reset)
        (cnt_evt && st_q.count == 8'hff && !wr_en)
            |=> (overflow_pulse && count_out == $past(st_q.preload));
    endproperty
    a_overflow_reload: assert property (p_overflow_reload) // R7
        else $error("overflow did not reload preload");

    property p_overflow_cause;
        @(posedge clk) disable iff (reset)
        overflow_pulse |-> $past(st_q.count) == 8'hff;
    endproperty
    a_overflow_cause: assert property (p_overflow_cause) // R6
        else $error("overflow without full count");

    property p_increment;
        @(posedge clk) disable iff (reset)
        (cnt_evt && st_q.count != 8'hff && !wr_en)
            |=> count_out == $past(st_q.count) + 8'h01;
    endproperty
    a_increment: assert property (p_increment) // R5
        else $error("count did not increment by one");

    property p_hold_when_off;
        @(posedge clk) disable iff (reset)
        (!st_q.ctrl.count_enable_bit && !wr_en) |=> $stable(count_out);
    endproperty
    a_hold_when_off: assert property (p_hold_when_off) // R12
        else $error("counter moved while disabled");

    property p_write_stopped;
        @(posedge clk) disable iff (reset)
        (wr_en && apb_req.paddr == ETC_OFF_COUNT
            && !st_q.ctrl.count_enable_bit)
            |=> count_out == $past(apb_req.pwdata[7:0]);
    endproperty
    a_write_stopped: assert property (p_write_stopped) // R9
        else $error("stopped write did not load counter");

    property p_write_running;
        @(posedge clk) disable iff (reset)
        (wr_en && apb_req.paddr == ETC_OFF_COUNT
            && st_q.ctrl.count_enable_bit && !cnt_evt)
            |=> ($stable(count_out)
                && st_q.preload == $past(apb_req.pwdata[7:0]));
    endproperty
    a_write_running: assert property (p_write_running) // R10
        else $error("running write touched counter");

    property p_event_edge;
        @(posedge clk) disable iff (reset)
        (mode_event && st_q.ctrl.count_enable_bit
            && !st_q.ctrl.active_edge_select && pin_rise) |-> cnt_evt;
    endproperty
    a_event_edge: assert property (p_event_edge) // R4
        else $error("rising edge not counted");

    property p_pulse_stop;
        @(posedge clk) disable iff (reset)
        (st_q.pulse_run && end_edge && mode_pulse && !wr_en)
            |=> !st_q.ctrl.count_enable_bit;
    endproperty
    a_pulse_stop: assert property (p_pulse_stop) // R20
        else $error("pulse end did not clear enable");

    property p_timer_tick;
        @(posedge clk) disable iff (reset)
        (mode_timer && st_q.ctrl.count_enable_bit) |-> cnt_evt == psc_tick;
    endproperty
    a_timer_tick: assert property (p_timer_tick) // R2
        else $error("timer not driven by prescaler");

    property p_overflow_event;
        @(posedge clk) disable iff (reset)
        overflow_pulse |-> $past(cnt_evt);
    endproperty
    a_overflow_event: assert property (p_overflow_event) // R6
        else $error("overflow without a count event");

    property p_unused_mode;
        @(posedge clk) disable iff (reset)
        (st_q.ctrl.mode_select == ETC_MODE_UNUSED) |-> !cnt_evt;
    endproperty
    a_unused_mode: assert property (p_unused_mode) // R17
        else $error("unused mode counted");

    property p_event_fall;
        @(posedge clk) disable iff (reset)
        (mode_event && st_q.ctrl.count_enable_bit
            && st_q.ctrl.active_edge_select && pin_fall) |-> cnt_evt;
    endproperty
    a_event_fall: assert property (p_event_fall) // R19
        else $error("falling edge not counted");

    property p_event_polarity;
        @(posedge clk) disable iff (reset)
        (mode_event && !st_q.ctrl.active_edge_select && pin_fall)
            |-> !cnt_evt;
    endproperty
    a_event_polarity: assert property (p_event_polarity) // R15
        else $error("inactive edge counted");

    property p_sub_source;
        @(posedge clk) disable iff (reset)
        (mode_timer && st_q.ctrl.internal_source_select && !sub_tick)
            |-> !cnt_evt;
    endproperty
    a_sub_source: assert property (p_sub_source) // R3
        else $error("timer counted without sub clock tick");

    property p_pulse_gate;
        @(posedge clk) disable iff (reset)
        (mode_pulse && !st_q.pulse_run) |-> !cnt_evt;
    endproperty
    a_pulse_gate: assert property (p_pulse_gate) // R20
        else $error("pulse mode counted outside the pulse");

    property p_pulse_start;
        @(posedge clk) disable iff (reset)
        (mode_pulse && st_q.ctrl.count_enable_bit && !st_q.pulse_run
            && act_edge && !wr_en) |=> st_q.pulse_run;
    endproperty
    a_pulse_start: assert property (p_pulse_start) // R20
        else $error("active edge did not open the pulse gate");

    property p_pulse_level;
        @(posedge clk) disable iff (reset)
        (st_q.pulse_run && !end_edge)
            |-> pin_level == st_q.ctrl.active_edge_select;
    endproperty
    a_pulse_level: assert property (p_pulse_level) // R19
        else $error("pulse gate open at the idle pin level");

    property p_enable_kept;
        @(posedge clk) disable iff (reset)
        (st_q.ctrl.count_enable_bit && !mode_pulse && !wr_en)
            |=> st_q.ctrl.count_enable_bit;
    endproperty
    a_enable_kept: assert property (p_enable_kept) // R12
        else $error("enable cleared outside pulse mode");

    property p_preload_kept;
        @(posedge clk) disable iff (reset)
        !(wr_en && apb_req.paddr == ETC_OFF_COUNT) |=> $stable(st_q.preload);
    endproperty
    a_preload_kept: assert property (p_preload_kept) // R10
        else $error("preload changed without a count write");

    property p_read_count;
        @(posedge clk) disable iff (reset)
        (rd_en && apb_req.paddr == ETC_OFF_COUNT)
            |=> apb_rsp.prdata == {24'h00_0000, $past(count_out)};
    endproperty
    a_read_count: assert property (p_read_count) // R8
        else $error("count read did not return live count");

    c_overflow: cover property (@(posedge clk) disable iff (reset)
        overflow_pulse);
    c_pulse_done: cover property (@(posedge clk) disable iff (reset)
        st_q.pulse_run ##1 !st_q.ctrl.count_enable_bit);
    c_event_cnt: cover property (@(posedge clk) disable iff (reset)
        mode_event && cnt_evt);
    c_running_write: cover property (@(posedge clk) disable iff (reset)
        wr_en && apb_req.paddr == ETC_OFF_COUNT && st_q.ctrl.count_enable_bit);

endmodule
`default_nettype wire

/* File: verif/etc_pin_src.sv */
// Purpose: external event and pulse source driving the timer pin
// Assumes: pin is push-pull and always driven, so never left floating
// Notes:   changes only just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module etc_pin_src (
    input  wire logic clk,
    output logic      pin
);
    initial pin = 1'b0;

    // drive a level, then keep it for a number of cycles
    task automatic hold(input logic lvl, input int cyc);
        @(posedge clk);
        pin <= lvl;
        repeat (cyc) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: verif/test_event_timer_counter_8bit.sv */
// Purpose: self-checking bench for the 8-bit event timer counter
// Assumes: zero-wait apb slave, pin source model on the event pin
// Notes:   sub tick pulses once every four cycles
`timescale 1ns/1ps
`default_nettype none
module test_event_timer_counter_8bit;
    import etc_pkg::*;
    logic         clk = 1'b0;
    logic         reset = 1'b1;
    etc_apb_req_t req;
    etc_apb_rsp_t rsp;
    logic         sub_tick = 1'b0;
    logic [1:0]   sub_cnt = 2'h0;
    logic         ovf;
    logic [7:0]   cnt;
    wire logic    pin;
    int           failures = 0;
    int           n_tests = 0;
    int           cyc = 0;
    logic [31:0]  rd;
    logic         er;

    always #25 clk = ~clk;

    etc_timer u_dut (.clk(clk), .reset(reset), .apb_req(req),
        .apb_rsp(rsp), .sub_tick(sub_tick), .external_event_pin(pin),
        .overflow_pulse(ovf), .count_out(cnt));
    etc_pin_src u_src (.clk(clk), .pin(pin));

    always @(posedge clk) begin
        sub_cnt  <= sub_cnt + 2'h1;
        sub_tick <= (sub_cnt == 2'h3);
    end

    task automatic conclude();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= w;
        req.paddr   <= a;
        req.pwdata  <= d;
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1) @(posedge clk);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    task automatic wait_ovf();
        while (ovf !== 1'b1) @(posedge clk);
    endtask

    // cycles between two overflow pulses
    task automatic period(input int exp);
        int n;
        wait_ovf();
        @(posedge clk);
        n = 1;
        while (ovf !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        check(n, exp);
    endtask

    initial begin
        req = '0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rdc(ETC_OFF_COUNT, 32'h0000_0000);
        rdc(ETC_OFF_CONTROL, 32'h0000_0008);
        wr(12'h008, 32'h0000_00ff);
        apb(1'b0, 12'h008, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check(er, 1'b1);
        $display("test reset done");
        wr(ETC_OFF_COUNT, 32'h0000_0010);
        rdc(ETC_OFF_COUNT, 32'h0000_0010);
        wr(ETC_OFF_CONTROL, 32'h0000_0010);
        repeat (40) @(posedge clk);
        rdc(ETC_OFF_COUNT, 32'h0000_0010);
        rdc(ETC_OFF_CONTROL, 32'h0000_0010);
        $display("test load done");
        for (int p = 0; p < 8; p++) begin
            wr(ETC_OFF_CONTROL, 32'h0000_0080);
            wr(ETC_OFF_COUNT, 32'h0000_00f0);
            wr(ETC_OFF_CONTROL, 32'h0000_0090 | p);
            period(16 << p);
            check(cnt, 8'hf0);
        end
        wr(ETC_OFF_CONTROL, 32'h0000_0080);
        wr(ETC_OFF_COUNT, 32'h0000_0000);
        wr(ETC_OFF_CONTROL, 32'h0000_0090);
        period(256);
        wr(ETC_OFF_COUNT, 32'h0000_0080);
        @(posedge clk);
        check(cnt == 8'h80, 1'b0);
        wait_ovf();
        check(cnt, 8'h80);
        period(128);
        wr(ETC_OFF_CONTROL, 32'h0000_0080);
        apb(1'b0, ETC_OFF_COUNT, 32'h0000_0000);
        repeat (20) @(posedge clk);
        rdc(ETC_OFF_COUNT, rd);
        wr(ETC_OFF_COUNT, 32'h0000_00f0);
        wr(ETC_OFF_CONTROL, 32'h0000_00b1);
        period(128);
        $display("test timer done");
        for (int e = 0; e < 2; e++) begin
            wr(ETC_OFF_CONTROL, 32'h0000_0040);
            u_src.hold(1'b0, 8);
            wr(ETC_OFF_COUNT, 32'h0000_0000);
            wr(ETC_OFF_CONTROL, 32'h0000_0077 | (e << 3));
            u_src.hold(1'b1, 8);
            rdc(ETC_OFF_COUNT, (e == 0) ? 1 : 0);
            u_src.hold(1'b0, 8);
            rdc(ETC_OFF_COUNT, 32'h0000_0001);
            repeat (3) begin
                u_src.hold(1'b1, 6);
                u_src.hold(1'b0, 6);
            end
            rdc(ETC_OFF_COUNT, 32'h0000_0004);
        end
        $display("test event done");
        wr(ETC_OFF_CONTROL, 32'h0000_00c0);
        u_src.hold(1'b1, 8);
        wr(ETC_OFF_COUNT, 32'h0000_0000);
        wr(ETC_OFF_CONTROL, 32'h0000_00d0);
        u_src.hold(1'b1, 20);
        rdc(ETC_OFF_COUNT, 32'h0000_0000);
        u_src.hold(1'b0, 40);
        u_src.hold(1'b1, 10);
        rdc(ETC_OFF_CONTROL, 32'h0000_00c0);
        apb(1'b0, ETC_OFF_COUNT, 32'h0000_0000);
        check(32'(rd >= 39 && rd <= 41), 32'h0000_0001);
        u_src.hold(1'b0, 30);
        u_src.hold(1'b1, 10);
        rdc(ETC_OFF_COUNT, rd);
        wr(ETC_OFF_CONTROL, 32'h0000_00c8);
        u_src.hold(1'b0, 8);
        wr(ETC_OFF_COUNT, 32'h0000_0000);
        wr(ETC_OFF_CONTROL, 32'h0000_00d8);
        u_src.hold(1'b1, 20);
        u_src.hold(1'b0, 10);
        rdc(ETC_OFF_CONTROL, 32'h0000_00c8);
        apb(1'b0, ETC_OFF_COUNT, 32'h0000_0000);
        check(32'(rd >= 19 && rd <= 21), 32'h0000_0001);
        $display("test pulse done");
        conclude();
    end
endmodule
`default_nettype wire
